// file: src/dtcc_top.sv
// Data transfer controller: APB register file plus transfer engine.
// Assumes a single 125 MHz clock, synchronous active-high reset and
// a RAM/peripheral bus that answers each unit request with an ack.
//
// What this block does
// - Engine runs only while clock gate bit set
// - Five 8-bit groups hold per-source enables; only sources 0 to 23 can activate
// - Base register locates the control data area
// - Size bit picks byte or word units
// - Repeat interrupt bit gates repeat-end interrupt
// - Normal mode ignores repeat interrupt bit
// - Chain bit runs next channel same activation, except on the last channel (23)
// - Destination increments when its bit set
// - Repeat destination area ignores destination bit
// - Source increments when its bit set
// - Repeat source area ignores source bit
// - Area select picks destination or source
// - Normal mode ignores area select bit
// - Mode bit picks normal or repeat
// - Block size zero means 256 units
// - Transfer count zero means 256 transfers
`timescale 1ns/10ps
`include "dtcc_cfg.svh"

module dtcc_top
	import dtcc_pkg::*;
#(
	parameter int NCH  = 24,
	parameter int NGRP = 5
)(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        ce_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [11:0] paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	input  wire logic [8*NGRP-1:0] act_req_i,
	input  wire logic        xfer_ack_i,
	output logic             xfer_req_o,
	output logic      [15:0] xfer_src_o,
	output logic      [15:0] xfer_dst_o,
	output logic             xfer_wide_o,
	output logic      [15:0] desc_addr_o,
	output logic             rpt_irq_o,
	output logic             done_o
);

	localparam int NSRC = 8 * NGRP;

	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	logic              gate;
	logic [7:0]        base;
	logic [7:0]        en   [NGRP];
	logic [7:0]        ctl  [NCH];
	logic [7:0]        blk  [NCH];
	logic [7:0]        cnt  [NCH];
	logic [7:0]        rld  [NCH];
	logic [15:0]       src  [NCH];
	logic [15:0]       dst  [NCH];
	logic [15:0]       ofs  [NCH];
	logic [NSRC-1:0]   pend;
	dtcc_state_t       state;
	logic [4:0]        ch;
	logic [8:0]        units;

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	wire        acc    = psel_i & penable_i;
	wire        wr_go  = acc & pready_o & pwrite_i;
	wire [4:0]  wch    = paddr_i[9:5];
	wire [2:0]  fld    = paddr_i[4:2];
	wire        ch_ok  = paddr_i[`DTCC_CH_AREA_BIT] & ~paddr_i[11]
		& (32'(wch) < NCH) & (fld <= `DTCC_FLD_DST)
		& (paddr_i[1:0] == 2'h0);
	wire [11:0] en_ofs = paddr_i - `DTCC_OFS_EN0;
	wire        en_hit = (paddr_i >= `DTCC_OFS_EN0)
		& (paddr_i < `DTCC_OFS_BASE) & (en_ofs[1:0] == 2'h0);
	wire [2:0]  en_idx = en_ofs[4:2];
	wire        g_ok   = (paddr_i == `DTCC_OFS_GATE)
		| (paddr_i == `DTCC_OFS_BASE)
		| (paddr_i == `DTCC_OFS_STAT) | en_hit;
	wire        wr_ch  = wr_go & ch_ok;
	wire        wr_en  = wr_go & en_hit;

	// ------------------------------------------------------------
	// Engine decode
	// ------------------------------------------------------------
	// Clock gate cuts the engine but leaves the registers reachable
	wire        eng_en = ce_i & gate;
	wire [7:0]  c      = ctl[ch];
	wire        rpt    = c[`DTCC_MODE_BIT];
	// Area select only counts in repeat mode
	wire        rsrc   = rpt & c[`DTCC_RSEL_BIT];
	wire        rdst   = rpt & ~c[`DTCC_RSEL_BIT];
	wire [15:0] step   = c[`DTCC_SZ_BIT] ? 16'h0002 : 16'h0001;
	wire        s_inc  = c[`DTCC_SINC_BIT] & ~rsrc;
	wire        d_inc  = c[`DTCC_DINC_BIT] & ~rdst;
	wire [15:0] e_src  = src[ch] + (rsrc ? ofs[ch] : 16'h0000);
	wire [15:0] e_dst  = dst[ch] + (rdst ? ofs[ch] : 16'h0000);
	wire        chain  = c[`DTCC_CHAIN_ENABLE_BIT]
		& (32'(ch) != NCH - 1);
	wire [4:0]  ch_nx  = ch + 5'h01;
	wire        unit_d = eng_en & (state == DTCC_WAIT) & xfer_ack_i;
	wire        blk_d  = unit_d & (units == 9'h001);
	// Count of 00H reaches 1 only after wrapping, giving 256 runs
	wire        cnt_e  = blk_d & (cnt[ch] == 8'h01);

	logic [NSRC-1:0] en_flat;
	logic [NCH-1:0]  hit;
	logic            pick_ok;
	logic [4:0]      pick;

	always_comb
	begin
		for (int g = 0; g < NGRP; g++)
			en_flat[8*g +: 8] = en[g];
	end

	// Sources past the last channel have no descriptor and never start
	assign hit = pend[NCH-1:0] & en_flat[NCH-1:0];

	always_comb
	begin
		pick_ok = 1'b0;
		pick    = 5'h00;
		for (int i = NCH - 1; i >= 0; i--)
			if (hit[i])
			begin
				pick_ok = 1'b1;
				pick    = 5'(i);
			end
	end

	wire take = eng_en & (state == DTCC_IDLE) & pick_ok;

	function automatic logic [8:0] units_of(input logic [7:0] b);
		units_of = (b == 8'h00) ? 9'h100 : {1'b0, b};
	endfunction

	// ------------------------------------------------------------
	// Pending activations
	// ------------------------------------------------------------
	// A request in the cycle its bit is taken stays pending
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			pend <= '0;
		else if (eng_en)
			pend <= (pend & ~(take ? NSRC'(1) << pick : '0))
				| act_req_i;
	end

	// ------------------------------------------------------------
	// Global registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			gate <= 1'b0;
			base <= `DTCC_RST_BYTE;
			for (int g = 0; g < NGRP; g++)
				en[g] <= `DTCC_RST_BYTE;
		end
		else if (ce_i)
		begin
			// Normal-mode end disarms its source
			if (cnt_e & ~rpt)
				en[ch[4:3]][ch[2:0]] <= 1'b0;
			// Software write last, so a re-arm wins
			if (wr_en & (32'(en_idx) < NGRP))
				en[en_idx] <= pwdata_i[7:0];
			if (wr_go & (paddr_i == `DTCC_OFS_GATE))
				gate <= pwdata_i[`DTCC_GATE_BIT];
			if (wr_go & (paddr_i == `DTCC_OFS_BASE))
				base <= pwdata_i[7:0];
		end
	end

	// ------------------------------------------------------------
	// Channel descriptors
	// ------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			for (int i = 0; i < NCH; i++)
			begin
				ctl[i] <= `DTCC_RST_BYTE;
				blk[i] <= `DTCC_RST_BYTE;
				cnt[i] <= `DTCC_RST_BYTE;
				rld[i] <= `DTCC_RST_BYTE;
				src[i] <= `DTCC_RST_ADDR;
				dst[i] <= `DTCC_RST_ADDR;
				ofs[i] <= `DTCC_RST_ADDR;
			end
		end
		else if (ce_i)
		begin
			if (unit_d)
			begin
				if (s_inc)
					src[ch] <= src[ch] + step;
				if (d_inc)
					dst[ch] <= dst[ch] + step;
				if (rsrc | rdst)
					ofs[ch] <= ofs[ch] + step;
			end
			if (blk_d)
				cnt[ch] <= cnt[ch] - 8'h01;
			// Repeat end rewinds the area and reloads the count
			if (cnt_e & rpt)
			begin
				cnt[ch] <= rld[ch];
				ofs[ch] <= `DTCC_RST_ADDR;
			end
			if (wr_ch)
			begin
				case (fld)
					`DTCC_FLD_CTL:
						ctl[wch] <= pwdata_i[7:0]
							& `DTCC_CTL_MASK;
					`DTCC_FLD_BLK: blk[wch] <= pwdata_i[7:0];
					`DTCC_FLD_CNT: cnt[wch] <= pwdata_i[7:0];
					`DTCC_FLD_RLD: rld[wch] <= pwdata_i[7:0];
					`DTCC_FLD_SRC: src[wch] <= pwdata_i[15:0];
					`DTCC_FLD_DST: dst[wch] <= pwdata_i[15:0];
					default: ;
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// Transfer engine
	// ------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state       <= DTCC_IDLE;
			ch          <= 5'h00;
			units       <= 9'h000;
			xfer_req_o  <= 1'b0;
			xfer_src_o  <= 16'h0000;
			xfer_dst_o  <= 16'h0000;
			xfer_wide_o <= 1'b0;
			desc_addr_o <= 16'h0000;
			rpt_irq_o   <= 1'b0;
			done_o      <= 1'b0;
		end
		else if (eng_en)
		begin
			rpt_irq_o <= cnt_e & rpt & c[`DTCC_REPEAT_IRQ_ENABLE_BIT];
			done_o    <= cnt_e & ~rpt;
			case (state)
				DTCC_IDLE:
					if (pick_ok)
					begin
						ch    <= pick;
						units <= units_of(blk[pick]);
						state <= DTCC_LOAD;
					end
				DTCC_LOAD:
				begin
					xfer_src_o  <= e_src;
					xfer_dst_o  <= e_dst;
					xfer_wide_o <= c[`DTCC_SZ_BIT];
					desc_addr_o <= {base, ch, 3'h0};
					xfer_req_o  <= 1'b1;
					state       <= DTCC_WAIT;
				end
				DTCC_WAIT:
					if (xfer_ack_i)
					begin
						xfer_req_o <= 1'b0;
						units      <= units - 9'h001;
						if (units != 9'h001)
							state <= DTCC_LOAD;
						else if (chain)
						begin
							ch    <= ch_nx;
							units <= units_of(blk[ch_nx]);
							state <= DTCC_LOAD;
						end
						else
							state <= DTCC_IDLE;
					end
				default:
					state <= DTCC_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// APB slave, one wait state so read data comes from a flop
	// ------------------------------------------------------------
	logic [31:0] rd_mux;

	always_comb
	begin
		rd_mux = 32'h0000_0000;
		if (ch_ok)
		begin
			case (fld)
				`DTCC_FLD_CTL: rd_mux = {24'h0, ctl[wch]};
				`DTCC_FLD_BLK: rd_mux = {24'h0, blk[wch]};
				`DTCC_FLD_CNT: rd_mux = {24'h0, cnt[wch]};
				`DTCC_FLD_RLD: rd_mux = {24'h0, rld[wch]};
				`DTCC_FLD_SRC: rd_mux = {16'h0, src[wch]};
				`DTCC_FLD_DST: rd_mux = {16'h0, dst[wch]};
				default:       rd_mux = 32'h0000_0000;
			endcase
		end
		else if (en_hit & (32'(en_idx) < NGRP))
			rd_mux = {24'h0, en[en_idx]};
		else if (paddr_i == `DTCC_OFS_GATE)
			rd_mux = {28'h0, gate, 3'h0};
		else if (paddr_i == `DTCC_OFS_BASE)
			rd_mux = {24'h0, base};
		else if (paddr_i == `DTCC_OFS_STAT)
			rd_mux = {26'h0, state != DTCC_IDLE, ch};
	end

	wire addr_ok = ch_ok | (g_ok & ~(en_hit & (32'(en_idx) >= NGRP)));

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o  <= 32'h0000_0000;
		end
		else if (ce_i)
		begin
			pready_o  <= acc & ~pready_o;
			pslverr_o <= acc & ~pready_o & ~addr_ok;
			prdata_o  <= (acc & ~pready_o & ~pwrite_i) ? rd_mux
				: 32'h0000_0000;
		end
	end

endmodule // dtcc_top

// file: src/dtcc_cfg.svh
// Register map, field positions and reset values of the transfer
// controller. Included by the controller; holds definitions only.
`ifndef DTCC_CFG_SVH
`define DTCC_CFG_SVH

// ------------------------------------------------------------
// Global register byte offsets
// ------------------------------------------------------------
`define DTCC_OFS_GATE   12'h000
`define DTCC_OFS_EN0    12'h004
`define DTCC_OFS_BASE   12'h018
`define DTCC_OFS_STAT   12'h01C

// ------------------------------------------------------------
// Channel area: bit 10 set, channel in 9:5, field in 4:2
// ------------------------------------------------------------
`define DTCC_CH_AREA_BIT 10
`define DTCC_FLD_CTL    3'h0
`define DTCC_FLD_BLK    3'h1
`define DTCC_FLD_CNT    3'h2
`define DTCC_FLD_RLD    3'h3
`define DTCC_FLD_SRC    3'h4
`define DTCC_FLD_DST    3'h5

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define DTCC_GATE_BIT   3
`define DTCC_SZ_BIT     6
`define DTCC_REPEAT_IRQ_ENABLE_BIT 5
`define DTCC_CHAIN_ENABLE_BIT   4
`define DTCC_DINC_BIT   3
`define DTCC_SINC_BIT   2
`define DTCC_RSEL_BIT   1
`define DTCC_MODE_BIT   0
`define DTCC_CTL_MASK   8'h7F

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define DTCC_RST_BYTE   8'h00
`define DTCC_RST_ADDR   16'h0000

`endif

// file: src/dtcc_pkg.sv
// Types shared by the transfer controller.
// Assumes the configuration header for all numeric constants.
package dtcc_pkg;
	typedef enum logic [1:0] {
		DTCC_IDLE,
		DTCC_LOAD,
		DTCC_WAIT
	} dtcc_state_t;
endpackage

// file: bench/dtcc_bus_model.sv
// Far-side bus: acknowledges each unit request after a set stall.
// Assumes the controller holds its request until acknowledged.
`timescale 1ns/10ps
module dtcc_bus_model (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       req_i,
	input  wire logic [3:0] stall_i,
	output logic            ack_o
);
	logic [3:0] wait_cnt;
	// Ack lasts one edge, so one request is never taken twice
	always_ff @(posedge clk_i)
	begin
		if (rst_i || !req_i || ack_o)
		begin
			wait_cnt <= 4'h0;
			ack_o    <= 1'h0;
		end
		else if (wait_cnt == stall_i)
			ack_o <= 1'h1;
		else
			wait_cnt <= wait_cnt + 4'h1;
	end
endmodule // dtcc_bus_model

// file: bench/dtcc_monitor.sv
// Port checker for the transfer controller.
// Assumes ce_i stays high; bound into every dtcc_top.
`timescale 1ns/10ps
module dtcc_monitor (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic [31:0] prdata_o,
	input wire logic        pready_o,
	input wire logic        pslverr_o,
	input wire logic        xfer_ack_i,
	input wire logic        xfer_req_o,
	input wire logic [15:0] xfer_src_o,
	input wire logic [15:0] xfer_dst_o,
	input wire logic        rpt_irq_o,
	input wire logic        done_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence acc_s;
		psel_i && penable_i && !pready_o;
	endsequence
	sequence unit_s;
		xfer_req_o && xfer_ack_i;
	endsequence
	apb_answer_a:
		assert property (acc_s |=> pready_o) else $error("late answer");
	ready_pulse_a:
		assert property (pready_o |=> !pready_o) else $error("long ready");
	ready_access_a:
		assert property (pready_o |-> psel_i && penable_i)
		else $error("stray ready");
	err_ready_a:
		assert property (pslverr_o |-> pready_o) else $error("stray error");
	rdata_quiet_a:
		assert property (!pready_o |-> prdata_o == 32'h0)
		else $error("stray read data");
	req_hold_a:
		assert property (xfer_req_o && !xfer_ack_i |=> xfer_req_o &&
			$stable(xfer_src_o) && $stable(xfer_dst_o))
		else $error("request dropped or moved");
	unit_end_a:
		assert property (unit_s |=> !xfer_req_o) else $error("request stuck");
	end_pulse_a:
		assert property (done_o || rpt_irq_o |=> !done_o && !rpt_irq_o)
		else $error("long end pulse");
	end_cause_a:
		assert property (done_o || rpt_irq_o |-> $past(xfer_ack_i))
		else $error("end without unit");
	mode_excl_a:
		assert property (!(done_o && rpt_irq_o)) else $error("both ends");
endmodule // dtcc_monitor

bind dtcc_top dtcc_monitor u_mon (.clk_i, .rst_i, .psel_i, .penable_i,
	.prdata_o, .pready_o, .pslverr_o, .xfer_ack_i, .xfer_req_o,
	.xfer_src_o, .xfer_dst_o, .rpt_irq_o, .done_o);

// file: bench/test_dtcc_top.sv
// Self-checking bench for the transfer controller.
// Assumes bus model and checker are compiled before it.
`timescale 1ns/10ps
module test_dtcc_top;
	logic        clk = 1'h0;
	logic        rst = 1'h1;
	logic        psel = 1'h0;
	logic        pen = 1'h0;
	logic        pwr = 1'h0;
	logic [11:0] pa = 12'h000;
	logic [31:0] pwd = 32'h0;
	logic [39:0] act = 40'h0;
	logic [3:0]  stall = 4'h0;
	logic [31:0] prd;
	logic        rdy, err, ack, req, wide, done, irq;
	logic [15:0] src, dst, dsc;
	logic [48:0] units[$];
	int          fails = 0;
	int          checks_done = 0;
	int          n_done = 0;
	int          n_irq = 0;

	initial
	begin
		forever #4 clk = ~clk;
	end

	dtcc_top DUT (.clk_i(clk), .rst_i(rst), .ce_i(1'h1), .psel_i(psel),
		.penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd),
		.prdata_o(prd), .pready_o(rdy), .pslverr_o(err), .act_req_i(act),
		.xfer_ack_i(ack), .xfer_req_o(req), .xfer_src_o(src),
		.xfer_dst_o(dst), .xfer_wide_o(wide), .desc_addr_o(dsc),
		.rpt_irq_o(irq), .done_o(done));
	dtcc_bus_model u_bus (.clk_i(clk), .rst_i(rst), .req_i(req),
		.stall_i(stall), .ack_o(ack));

	always @(posedge clk)
	begin
		if (req && ack)
			units.push_back({dsc, wide, src, dst});
		n_done += done;
		n_irq += irq;
	end

	task automatic end_sim();
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(string n, logic [63:0] x, logic [63:0] g);
		checks_done++;
		if (g !== x)
		begin
			fails++;
			$display("BAD %s exp %h got %h", n, x, g);
		end
	endtask

	// ----------------------------------------
	// APB master and transfer helpers
	// ----------------------------------------
	task automatic apb(logic w, logic [11:0] a, logic [31:0] d,
		output logic [31:0] r, output logic e);
		int t;
		psel <= 1'h1;
		pwr <= w;
		pa <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'h1;
		for (t = 0; t < 20; t++)
		begin
			@(posedge clk);
			if (rdy === 1'h1)
				break;
		end
		r = prd;
		e = err;
		psel <= 1'h0;
		pen <= 1'h0;
		@(posedge clk);
		if (t == 20)
		begin
			fails++;
			end_sim();
		end
	endtask

	task automatic wr(logic [11:0] a, logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'h1, a, d, r, e);
	endtask

	task automatic rd(string n, logic [11:0] a, logic [31:0] x);
		logic [31:0] r;
		logic        e;
		apb(1'h0, a, 32'h0, r, e);
		chk(n, x, r);
	endtask

	function automatic logic [11:0] ca(int ch, int f);
		return 12'(32'h400 + ch * 32 + f * 4);
	endfunction

	task automatic setch(int ch, logic [7:0] c, b, n, logic [15:0] s, d);
		wr(ca(ch, 0), 32'(c));
		wr(ca(ch, 1), 32'(b));
		wr(ca(ch, 2), 32'(n));
		wr(ca(ch, 3), 32'(n));
		wr(ca(ch, 4), 32'(s));
		wr(ca(ch, 5), 32'(d));
	endtask

	// Pulses one source and waits for the expected unit count
	task automatic fire(int k, int n);
		int t;
		units.delete();
		n_done = 0;
		n_irq = 0;
		act[k] <= 1'h1;
		@(posedge clk);
		act[k] <= 1'h0;
		for (t = 0; t < 4000 && units.size() < n; t++)
			@(posedge clk);
		repeat (20) @(posedge clk);
		chk("units", n, units.size());
		if (t == 4000)
		begin
			fails++;
			end_sim();
		end
	endtask

	task automatic t_regs();
		logic [31:0] r;
		logic        e;
		rd("gate", 12'h000, 32'h0);
		wr(12'h018, 32'hFD);
		rd("base", 12'h018, 32'hFD);
		wr(12'h014, 32'hA5);
		rd("en4", 12'h014, 32'hA5);
		wr(ca(23, 0), 32'h6F);
		rd("ctl23", ca(23, 0), 32'h6F);
		wr(ca(4, 0), 32'hFF);
		rd("ctl4", ca(4, 0), 32'h7F);
		apb(1'h0, 12'h3F0, 32'h0, r, e);
		chk("slverr", 1, e);
		chk("bad rd", 0, r);
		$display("regs test ended");
	endtask

	task automatic t_gate();
		setch(0, 8'h2A, 8'h02, 8'h01, 16'h0100, 16'h0200);
		wr(12'h004, 32'h1);
		fire(0, 0);
		wr(12'h000, 32'h8);
		fire(5, 0);
		fire(0, 2);
		chk("u0", {16'hFD00, 1'h0, 16'h0100, 16'h0200}, units[0]);
		chk("u1", {16'hFD00, 1'h0, 16'h0100, 16'h0201}, units[1]);
		chk("done", 1, n_done);
		chk("irq", 0, n_irq);
		rd("en0", 12'h004, 32'h0);
		$display("gate test ended");
	endtask

	task automatic t_repeat();
		stall <= 4'h3;
		setch(1, 8'h65, 8'h02, 8'h01, 16'h0300, 16'h0400);
		wr(12'h004, 32'h2);
		fire(1, 2);
		chk("r0", {16'hFD08, 1'h1, 16'h0300, 16'h0400}, units[0]);
		chk("r1", {16'hFD08, 1'h1, 16'h0302, 16'h0402}, units[1]);
		chk("irq", 1, n_irq);
		chk("done", 0, n_done);
		fire(1, 2);
		chk("r2", {16'hFD08, 1'h1, 16'h0304, 16'h0400}, units[0]);
		$display("repeat test ended");
	endtask

	// Source as repeat area: its increment bit must not step the register
	task automatic t_rsrc();
		stall <= 4'h1;
		setch(4, 8'h07, 8'h02, 8'h01, 16'h0900, 16'h0A00);
		wr(12'h004, 32'h10);
		fire(4, 2);
		chk("s1", {16'hFD20, 1'h0, 16'h0901, 16'h0A00}, units[1]);
		chk("irq", 0, n_irq);
		fire(4, 2);
		chk("s2", {16'hFD20, 1'h0, 16'h0900, 16'h0A00}, units[0]);
		$display("source repeat test ended");
	endtask

	task automatic t_chain();
		stall <= 4'h0;
		setch(2, 8'h18, 8'h00, 8'h01, 16'h0500, 16'h0600);
		setch(3, 8'h08, 8'h01, 8'h01, 16'h0700, 16'h0800);
		wr(12'h004, 32'h4);
		fire(2, 257);
		chk("c255", {16'hFD10, 1'h0, 16'h0500, 16'h06FF}, units[255]);
		chk("c256", {16'hFD18, 1'h0, 16'h0700, 16'h0800}, units[256]);
		$display("chain test ended");
	endtask

	initial
	begin
		repeat (8) @(posedge clk);
		rst <= 1'h0;
		@(posedge clk);
		t_regs();
		t_gate();
		t_repeat();
		t_rsrc();
		t_chain();
		end_sim();
	end
endmodule // test_dtcc_top
